// File: port_ef_regs.vh
// Register offsets, field positions and reset values of the E/F port block
`ifndef PORT_EF_REGS_VH
`define PORT_EF_REGS_VH

`define OFS_PORT_E_DIRECTION 8'h00
`define OFS_PORT_E_PINS 8'h04
`define OFS_PORT_E_LATCH 8'h08
`define OFS_PORT_F_DIRECTION 8'h0C
`define OFS_PORT_F_PINS 8'h10
`define OFS_PORT_F_LATCH 8'h14
`define OFS_MODE_CONTROL 8'h18
`define OFS_ANALOG_PIN_CONFIG 8'h1C
`define OFS_COMPARATOR_CONTROL 8'h20

`define RST_DIRECTION 8'hFF
`define RST_PORT_E_LATCH 8'h00
`define RST_PORT_F_LATCH 8'h00
`define RST_MODE_CONTROL 7'h00
`define RST_ANALOG_PIN_CONFIG 4'h0
`define RST_COMPARATOR_CONTROL 3'h0

`define MODE_SLAVE_PORT_ENABLE 0
`define MODE_EXTERNAL_BUS_DISABLE 1
`define MODE_CAPTURE_TWO_ON_E7 2
`define MODE_SSP_SELECT_ON_F7 3
`define MODE_COMP1_OUT_ON_F2 4
`define MODE_COMP2_OUT_ON_F1 5
`define MODE_REFERENCE_ON_F5 6

`define ANALOG_ALL_DIGITAL 4'hF
`define COMPARATORS_OFF 3'h7

`define PIN_SLAVE_READ 0
`define PIN_SLAVE_WRITE 1
`define PIN_SLAVE_SELECT 2
`define PIN_E_CAPTURE_TWO 7
`define PIN_F_COMP2 1
`define PIN_F_COMP1 2
`define PIN_F_REFERENCE 5
`define PIN_F_SSP_SELECT 7

`endif

// File: sync_two_stage.v
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps

module sync_two_stage #(
	parameter WIDTH = 8
) (
	input wire mclk,
	input wire resetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// First stage feeds only the second one
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;

endmodule // sync_two_stage

// File: port_ef_ctrl.v
// Ports E and F: direction, latch, pin read and alternate pin roles behind AHB-Lite
`timescale 1ns/1ps
`include "port_ef_regs.vh"

// Functional notes
// - Direction bit 1 makes the pin an input, driver off.
// - Direction bit 0 makes the pin drive its latch bit.
// - Latch register reads return the latch, writes update it.
// - Port F has eight pins, each with own direction and latch bit.
// - After reset port F pins 6..0 are analog inputs reading zero.
// - E0 low while selected is a slave-port read of port D.
// - E1 low while selected is a slave-port write of port D.
// - E2 is the active-low slave-port select; strobes count only while low.
// - With the external bus on, port E carries address/data bits 15..8.
// - E7 may carry capture/compare unit two when the bus is off.
// - Both direction registers reset to all ones.
// - Port E pins reads pin levels, writes load the latch.
// - F7 may be the serial-port slave select input.
// - F1 carries comparator two output, F2 comparator one output.
// - F5 may carry the reference output; F3..F6 act as comparator inputs.
// - Slave-port enable turns E2..E0 into slave-port control inputs when the bus is off.
// - Port E I/O works only while the external bus is disabled.
module port_ef_ctrl (
	input wire mclk,
	input wire resetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Port pins
	input wire [7:0] e_pin_in,
	output reg [7:0] e_pin_out,
	output reg [7:0] e_pin_oe,
	input wire [7:0] f_pin_in,
	output reg [7:0] f_pin_out,
	output reg [7:0] f_pin_oe,
	// External memory bus, high address/data byte
	input wire [7:0] ext_bus_ad_out,
	input wire ext_bus_ad_oe,
	output reg [7:0] ext_bus_ad_in,
	// Capture/compare unit two on E7
	input wire capture_compare_unit_two_out,
	input wire capture_compare_unit_two_out_en,
	output reg capture_compare_unit_two_in,
	// Comparators, reference and serial-port select on port F
	input wire comparator_one_output,
	input wire comparator_two_output,
	output reg comparator_reference_connect,
	output reg ssp_select_n,
	// Slave-port strobes towards the port D data register
	output reg slave_port_read_active,
	output reg slave_port_write_pulse
);

	// ******************************************
	// Registers
	// ******************************************
	reg [7:0] port_e_direction_reg;
	reg [7:0] port_e_latch_reg;
	reg [7:0] port_f_direction_reg;
	reg [7:0] port_f_latch_reg;
	reg [6:0] mode_reg;
	reg [3:0] analog_cfg_reg;
	reg [2:0] comp_ctrl_reg;

	// One-hot state codes
	localparam BUS_IDLE = 2'b01;
	localparam BUS_WRITE_DATA = 2'b10;
	localparam STROBE_HIGH = 2'b01;
	localparam STROBE_LOW = 2'b10;

	reg [1:0] bus_state_reg;
	reg [1:0] bus_state_next;
	reg [7:0] wr_addr_reg;
	reg [1:0] strobe_state_reg;
	reg [1:0] strobe_state_next;

	wire [7:0] e_sync;
	wire [7:0] f_sync;
	wire slave_port_enable;
	wire external_bus_disable;
	wire port_f_digital;
	wire comparators_on;
	wire access;
	wire [7:0] rd_addr;
	wire slave_selected;
	wire write_data_phase;
	wire write_strobe_low;
	wire write_strobe_start;

	reg [7:0] e_out_next;
	reg [7:0] e_oe_next;
	reg [7:0] f_out_next;
	reg [7:0] f_oe_next;
	reg [7:0] f_read_value;
	reg [31:0] rdata_next;

	// ******************************************
	// Pin synchronisers
	// ******************************************
	sync_two_stage #(.WIDTH(8)) u_sync_e (
		.mclk(mclk),
		.resetn(resetn),
		.async_in(e_pin_in),
		.sync_out(e_sync)
	);

	sync_two_stage #(.WIDTH(8)) u_sync_f (
		.mclk(mclk),
		.resetn(resetn),
		.async_in(f_pin_in),
		.sync_out(f_sync)
	);

	assign slave_port_enable = mode_reg[`MODE_SLAVE_PORT_ENABLE];
	assign external_bus_disable = mode_reg[`MODE_EXTERNAL_BUS_DISABLE];
	assign port_f_digital = (analog_cfg_reg == `ANALOG_ALL_DIGITAL);
	assign comparators_on = (comp_ctrl_reg != `COMPARATORS_OFF);

	// ******************************************
	// AHB-Lite slave
	// ******************************************
	assign access = hsel & hready & htrans[1];
	assign rd_addr = {haddr[7:2], 2'b00};

	// Analog pins read zero; comparator inputs too while comparators run
	always @* begin
		f_read_value = f_sync;
		if (!port_f_digital) begin
			f_read_value[6:0] = 7'h00;
		end
		if (comparators_on) begin
			f_read_value[6:3] = 4'h0;
		end
	end

	always @* begin
		rdata_next = 32'h0000_0000;
		case (rd_addr)
			`OFS_PORT_E_DIRECTION: rdata_next[7:0] = port_e_direction_reg;
			`OFS_PORT_E_PINS: rdata_next[7:0] = e_sync;
			`OFS_PORT_E_LATCH: rdata_next[7:0] = port_e_latch_reg;
			`OFS_PORT_F_DIRECTION: rdata_next[7:0] = port_f_direction_reg;
			`OFS_PORT_F_PINS: rdata_next[7:0] = f_read_value;
			`OFS_PORT_F_LATCH: rdata_next[7:0] = port_f_latch_reg;
			`OFS_MODE_CONTROL: rdata_next[6:0] = mode_reg;
			`OFS_ANALOG_PIN_CONFIG: rdata_next[3:0] = analog_cfg_reg;
			`OFS_COMPARATOR_CONTROL: rdata_next[2:0] = comp_ctrl_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// ******************************************
	// Bus data-phase tracking
	// ******************************************
	// Write data arrive one cycle after the address phase, so the address waits
	always @* begin
		case (bus_state_reg)
			BUS_IDLE: begin
				bus_state_next = (access & hwrite) ? BUS_WRITE_DATA : BUS_IDLE;
			end
			// Back-to-back writes stay in the data phase
			BUS_WRITE_DATA: begin
				bus_state_next = (access & hwrite) ? BUS_WRITE_DATA : BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
	end

	assign write_data_phase = bus_state_reg[1];

	// Zero wait states; read data are sampled in the address phase
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			bus_state_reg <= BUS_IDLE;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			bus_state_reg <= bus_state_next;
			if (access) begin
				wr_addr_reg <= rd_addr;
				if (!hwrite) begin
					hrdata <= rdata_next;
				end
			end
		end
	end

	// ******************************************
	// Register writes
	// ******************************************
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			port_e_direction_reg <= `RST_DIRECTION;
			port_f_direction_reg <= `RST_DIRECTION;
			port_e_latch_reg <= `RST_PORT_E_LATCH;
			port_f_latch_reg <= `RST_PORT_F_LATCH;
			mode_reg <= `RST_MODE_CONTROL;
			analog_cfg_reg <= `RST_ANALOG_PIN_CONFIG;
			comp_ctrl_reg <= `RST_COMPARATOR_CONTROL;
		end else if (write_data_phase) begin
			case (wr_addr_reg)
				`OFS_PORT_E_DIRECTION: port_e_direction_reg <= hwdata[7:0];
				`OFS_PORT_E_PINS: port_e_latch_reg <= hwdata[7:0];
				`OFS_PORT_E_LATCH: port_e_latch_reg <= hwdata[7:0];
				`OFS_PORT_F_DIRECTION: port_f_direction_reg <= hwdata[7:0];
				`OFS_PORT_F_PINS: port_f_latch_reg <= hwdata[7:0];
				`OFS_PORT_F_LATCH: port_f_latch_reg <= hwdata[7:0];
				`OFS_MODE_CONTROL: mode_reg <= hwdata[6:0];
				`OFS_ANALOG_PIN_CONFIG: analog_cfg_reg <= hwdata[3:0];
				`OFS_COMPARATOR_CONTROL: comp_ctrl_reg <= hwdata[2:0];
				default: port_e_latch_reg <= port_e_latch_reg;
			endcase
		end
	end

	// ******************************************
	// Port E pin drivers
	// ******************************************
	// Overrides act on the drivers only, the direction bits stay as written
	always @* begin
		e_out_next = port_e_latch_reg;
		e_oe_next = ~port_e_direction_reg;
		// Port I/O exists only while the external bus is switched off
		if (!external_bus_disable) begin
			e_out_next = ext_bus_ad_out;
			e_oe_next = {8{ext_bus_ad_oe}};
		end else begin
			if (slave_port_enable) begin
				e_oe_next[2:0] = 3'b000;
			end
			if (mode_reg[`MODE_CAPTURE_TWO_ON_E7] && capture_compare_unit_two_out_en) begin
				e_out_next[`PIN_E_CAPTURE_TWO] = capture_compare_unit_two_out;
				e_oe_next[`PIN_E_CAPTURE_TWO] = 1'b1;
			end
		end
	end

	// ******************************************
	// Port F pin drivers
	// ******************************************
	always @* begin
		f_out_next = port_f_latch_reg;
		f_oe_next = ~port_f_direction_reg;
		if (mode_reg[`MODE_COMP2_OUT_ON_F1]) begin
			f_out_next[`PIN_F_COMP2] = comparator_two_output;
			f_oe_next[`PIN_F_COMP2] = 1'b1;
		end
		if (mode_reg[`MODE_COMP1_OUT_ON_F2]) begin
			f_out_next[`PIN_F_COMP1] = comparator_one_output;
			f_oe_next[`PIN_F_COMP1] = 1'b1;
		end
		// Digital driver must be off while the analog reference is on the pin
		if (mode_reg[`MODE_REFERENCE_ON_F5]) begin
			f_oe_next[`PIN_F_REFERENCE] = 1'b0;
		end
		if (mode_reg[`MODE_SSP_SELECT_ON_F7]) begin
			f_oe_next[`PIN_F_SSP_SELECT] = 1'b0;
		end
	end

	// ******************************************
	// Slave-port strobe tracking
	// ******************************************
	assign slave_selected = slave_port_enable & external_bus_disable &
		~e_sync[`PIN_SLAVE_SELECT];

	assign write_strobe_low = slave_selected & ~e_sync[`PIN_SLAVE_WRITE];

	// A strobe held low for many cycles must still capture only once
	always @* begin
		case (strobe_state_reg)
			STROBE_HIGH: begin
				strobe_state_next = write_strobe_low ? STROBE_LOW : STROBE_HIGH;
			end
			STROBE_LOW: begin
				strobe_state_next = write_strobe_low ? STROBE_LOW : STROBE_HIGH;
			end
			default: begin
				strobe_state_next = STROBE_HIGH;
			end
		endcase
	end

	assign write_strobe_start = write_strobe_low & strobe_state_reg[0];

	// Read strobe is a level: data stand for as long as the master holds it low
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strobe_state_reg <= STROBE_HIGH;
			slave_port_read_active <= 1'b0;
			slave_port_write_pulse <= 1'b0;
		end else begin
			strobe_state_reg <= strobe_state_next;
			slave_port_read_active <= slave_selected &
				~e_sync[`PIN_SLAVE_READ];
			// One capture per write strobe, on its falling edge
			slave_port_write_pulse <= write_strobe_start;
		end
	end

	// ******************************************
	// Registered outputs and alternate inputs
	// ******************************************

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			e_pin_out <= 8'h00;
			e_pin_oe <= 8'h00;
			f_pin_out <= 8'h00;
			f_pin_oe <= 8'h00;
			ext_bus_ad_in <= 8'h00;
			capture_compare_unit_two_in <= 1'b0;
			comparator_reference_connect <= 1'b0;
			ssp_select_n <= 1'b1;
		end else begin
			e_pin_out <= e_out_next;
			e_pin_oe <= e_oe_next;
			f_pin_out <= f_out_next;
			f_pin_oe <= f_oe_next;
			ext_bus_ad_in <= e_sync;
			capture_compare_unit_two_in <= e_sync[`PIN_E_CAPTURE_TWO];
			comparator_reference_connect <= mode_reg[`MODE_REFERENCE_ON_F5];
			ssp_select_n <= mode_reg[`MODE_SSP_SELECT_ON_F7] ?
				f_sync[`PIN_F_SSP_SELECT] : 1'b1;
		end
	end

endmodule // port_ef_ctrl

// File: port_ef_chk.sv
// Assertion checker for the E/F port block
`timescale 1ns/1ps
module port_ef_chk (
	input wire mclk,
	input wire resetn,
	input wire hsel,
	input wire hready,
	input wire hwrite,
	input wire [1:0] htrans,
	input wire [31:0] hrdata,
	input wire [7:0] e_pin_in,
	input wire [7:0] e_pin_oe,
	input wire [7:0] f_pin_in,
	input wire [7:0] ext_bus_ad_in,
	input wire capture_compare_unit_two_in,
	input wire ssp_select_n,
	input wire slave_port_read_active,
	input wire slave_port_write_pulse
);
	// Cycles since reset; pipelines still hold reset values before it saturates
	logic [1:0] age;
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn) age <= 2'h0;
		else if (age != 2'h3) age <= age + 2'h1;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_rd_idle;
		e_pin_in[0] [*3];
	endsequence
	sequence s_wr_idle;
		e_pin_in[1] [*3];
	endsequence
	a_rd_hold: assert property (
		!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata)) else $error("hrdata moved");
	a_sync_e: assert property (
		age == 2'h3 |-> ext_bus_ad_in == $past(e_pin_in, 3)) else $error("bus byte in");
	a_sync_ccp: assert property (
		age == 2'h3 |-> capture_compare_unit_two_in == $past(e_pin_in[7], 3))
		else $error("capture in");
	a_ssp_cause: assert property (
		age == 2'h3 && !ssp_select_n |-> !$past(f_pin_in[7], 3)) else $error("ssp select");
	a_rd_cause: assert property (
		age == 2'h3 && slave_port_read_active |-> !$past(e_pin_in[2], 3) && !$past(e_pin_in[0], 3))
		else $error("read no cause");
	a_rd_idle: assert property (
		s_rd_idle |=> !slave_port_read_active) else $error("read while idle");
	a_wr_idle: assert property (
		s_wr_idle |=> !slave_port_write_pulse) else $error("write while idle");
	a_wr_single: assert property (
		slave_port_write_pulse |=> !slave_port_write_pulse) else $error("long write pulse");
	a_wr_sel: assert property (
		age == 2'h3 && slave_port_write_pulse |-> !$past(e_pin_in[2], 3)) else $error("write unselected");
	a_slv_oe: assert property (
		slave_port_read_active |-> e_pin_oe[2:0] == 3'h0) else $error("strobe pin driven");
endmodule // port_ef_chk

// File: pin_board.sv
// Board model: pin levels and an external master on the slave-port strobes
`timescale 1ns/1ps
module pin_board (
	input wire mclk,
	input wire [1:0] cmd,
	input wire [7:0] e_out,
	input wire [7:0] e_oe,
	input wire [7:0] f_out,
	input wire [7:0] f_oe,
	input wire [7:0] e_far,
	input wire [7:0] f_far,
	output wire [7:0] e_pin,
	output wire [7:0] f_pin
);
	logic [2:0] strb = 3'h7;
	logic [3:0] cnt = 4'h0;
	logic [1:0] op = 2'h0;
	// Strobes can only pull E2..E0 low
	assign e_pin = (e_oe & e_out) | (~e_oe & e_far & {5'h1F, strb});
	assign f_pin = (f_oe & f_out) | (~f_oe & f_far);
	// Cmd 1 read, 2 write, 3 write strobe with select held high
	always @(posedge mclk) begin
		if (cnt == 4'h0) begin
			if (cmd != 2'h0) begin
				strb[2] <= (cmd == 2'h3);
				op <= cmd;
				cnt <= 4'h1;
			end
		end else begin
			cnt <= cnt + 4'h1;
			if (cnt == 4'h1) strb[op != 2'h1] <= 1'b0;
			if (cnt == 4'h6) strb[1:0] <= 2'h3;
			if (cnt == 4'h8) begin
				strb[2] <= 1'b1;
				cnt <= 4'h0;
			end
		end
	end
endmodule // pin_board

// File: tb_top.sv
// Self-checking testbench for the E/F port block
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] e_far = 8'hFF;
	logic [7:0] f_far = 8'hFF;
	logic [7:0] ad_out = 8'h00;
	logic ad_oe = 1'b0;
	logic ccp_o = 1'b0;
	logic ccp_en = 1'b0;
	logic c1 = 1'b0;
	logic c2 = 1'b0;
	logic [1:0] cmd = 2'h0;
	logic [31:0] q;
	wire [31:0] hrdata;
	wire hreadyout, hresp, ccp_in, cref, ssn, rda, wrp;
	wire [7:0] e_pin, f_pin, e_out, e_oe, f_out, f_oe, ad_in;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_wp = 0;
	int n_rd = 0;
	logic [7:0] t_a [7] = '{8'h00, 8'h08, 8'h0C, 8'h14, 8'h1C, 8'h20, 8'h24};
	logic [31:0] t_d [7] = '{32'h5A, 32'hC3, 32'h3C, 32'h96, 32'h0F, 32'h07, 32'h55};
	logic [31:0] t_e [7] = '{32'h5A, 32'hC3, 32'h3C, 32'h96, 32'h0F, 32'h07, 32'h00};

	port_ef_ctrl u_port_ef_ctrl (.mclk(mclk), .resetn(resetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .e_pin_in(e_pin), .e_pin_out(e_out),
		.e_pin_oe(e_oe), .f_pin_in(f_pin), .f_pin_out(f_out), .f_pin_oe(f_oe),
		.ext_bus_ad_out(ad_out), .ext_bus_ad_oe(ad_oe), .ext_bus_ad_in(ad_in),
		.capture_compare_unit_two_out(ccp_o), .capture_compare_unit_two_out_en(ccp_en),
		.capture_compare_unit_two_in(ccp_in),
		.comparator_one_output(c1), .comparator_two_output(c2),
		.comparator_reference_connect(cref), .ssp_select_n(ssn),
		.slave_port_read_active(rda), .slave_port_write_pulse(wrp));
	pin_board u_pin_board (.mclk(mclk), .cmd(cmd), .e_out(e_out), .e_oe(e_oe), .f_out(f_out),
		.f_oe(f_oe), .e_far(e_far), .f_far(f_far), .e_pin(e_pin), .f_pin(f_pin));

	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (wrp === 1'b1) n_wp++;
		if (rda === 1'b1) n_rd++;
		if (cyc == 3000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report;
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic psp(input logic [1:0] c, input int ew, input int er);
		n_wp = 0;
		n_rd = 0;
		@(posedge mclk);
		cmd <= c;
		@(posedge mclk);
		cmd <= 2'h0;
		repeat (14) @(posedge mclk);
		chk(n_wp, ew);
		chk(n_rd != 0, er);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		foreach (t_a[i]) begin
			bus(1'b1, t_a[i], t_d[i]);
			rd(t_a[i], t_e[i]);
			chk(hresp, 1'b0);
		end
		bus(1'b1, 8'h04, 32'hA5);
		rd(8'h08, 32'hA5);
		bus(1'b1, 8'h18, 32'h02);
		bus(1'b1, 8'h00, 32'h0F);
		e_far <= 8'h3C;
		repeat (3) @(posedge mclk);
		chk(e_oe, 8'hF0);
		chk(e_out & 8'hF0, 8'hA0);
		rd(8'h04, 32'hAC);
		ad_out <= 8'h69;
		ad_oe <= 1'b1;
		bus(1'b1, 8'h18, 32'h00);
		repeat (2) @(posedge mclk);
		chk({e_oe, e_out}, 16'hFF69);
		rd(8'h00, 32'h0F);
		f_far <= 8'h0A;
		repeat (3) @(posedge mclk);
		chk(f_oe, 8'hC3);
		rd(8'h10, 32'h8A);
		bus(1'b1, 8'h20, 32'h00);
		rd(8'h10, 32'h82);
		bus(1'b1, 8'h1C, 32'h00);
		rd(8'h10, 32'h80);
		c1 <= 1'b1;
		ccp_o <= 1'b1;
		ccp_en <= 1'b1;
		bus(1'b1, 8'h00, 32'hFF);
		bus(1'b1, 8'h0C, 32'hBC);
		bus(1'b1, 8'h18, 32'h7E);
		repeat (4) @(posedge mclk);
		chk({f_oe[2:1], f_out[2:1]}, 4'hE);
		chk(cref, 1'b1);
		chk(ssn, 1'b0);
		chk({e_oe[7], e_out[7]}, 2'h3);
		bus(1'b1, 8'h18, 32'h03);
		bus(1'b1, 8'h00, 32'h00);
		e_far <= 8'hFF;
		repeat (2) @(posedge mclk);
		chk(e_oe, 8'hF8);
		bus(1'b1, 8'h00, 32'h07);
		psp(2'h2, 1, 0);
		psp(2'h1, 0, 1);
		psp(2'h3, 0, 0);
		// ****************
		// Reset in mid-run
		// ****************
		ad_oe <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		rd(8'h00, 32'hFF);
		rd(8'h0C, 32'hFF);
		rd(8'h14, 32'h00);
		rd(8'h10, 32'h00);
		chk({e_oe, f_oe}, 16'h0);
		final_report();
	end
endmodule // tb_top

bind port_ef_ctrl port_ef_chk u_port_ef_chk (.*);
